// ==== lsu_pkg.sv ====
// Constants, register map and state type of the low-speed USB endpoint control block
package lsu_pkg;

    // Timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int SUSPEND_REQUEST_FLAG_IDLE_NS   = 3000000;
    localparam int SUSPEND_REQUEST_FLAG_IDLE_CYC  = (SUSPEND_REQUEST_FLAG_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W     = 19;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_TOKEN    = 6'h25;
    localparam logic [5:0] IDX_BASE_HI  = 6'h26;
    localparam logic [5:0] IDX_BASE_LO  = 6'h27;
    localparam logic [5:0] IDX_FLAGS    = 6'h28;
    localparam logic [5:0] IDX_MASK     = 6'h29;
    localparam logic [5:0] IDX_CTL      = 6'h2a;
    localparam logic [5:0] IDX_DEVICE_ADDRESS    = 6'h2b;
    localparam logic [5:0] IDX_EP0_TX   = 6'h2c;
    localparam logic [5:0] IDX_EP0_RX   = 6'h2d;
    localparam logic [5:0] IDX_EP1_TX   = 6'h2e;
    localparam logic [5:0] IDX_EP1_RX   = 6'h2f;
    localparam logic [5:0] IDX_EP2_TX   = 6'h30;
    localparam logic [5:0] IDX_EP2_RX   = 6'h31;

    // Event flag bit positions
    localparam int FLG_SOF   = 0;
    localparam int FLG_RST   = 1;
    localparam int FLG_END_OF_SUSPEND_FLAG = 2;
    localparam int FLG_SERVICE_OVERRUN_FLAG  = 3;
    localparam int FLG_ERR   = 4;
    localparam int FLG_CTR   = 5;
    localparam int FLG_BUFFER_OVERRUN_FLAG  = 6;
    localparam int FLG_SUSPEND_REQUEST_FLAG  = 7;

    // Control bit positions
    localparam int CTL_FORCED_INTERFACE_RESET   = 0;
    localparam int CTL_FORCED_LOW_POWER  = 1;
    localparam int CTL_REGULATOR_OFF_BIT   = 2;
    localparam int CTL_RESUME = 3;

    // Endpoint register field positions
    localparam int EP_DTOG = 6;
    localparam int EP_STH  = 5;
    localparam int EP_STL  = 4;

    // Endpoint status codes
    localparam logic [1:0] ST_DIS   = 2'h0;
    localparam logic [1:0] ST_STALL = 2'h1;
    localparam logic [1:0] ST_NAK   = 2'h2;
    localparam logic [1:0] ST_VALID = 2'h3;

    // Token type codes of a finished transfer
    localparam logic [1:0] TOK_OUT   = 2'h0;
    localparam logic [1:0] TOK_IN    = 2'h2;
    localparam logic [1:0] TOK_SETUP = 2'h3;

    // Reset values and bus answers
    localparam logic [3:0] CTL_RST  = 4'h6;
    localparam logic [7:0] EP0RX_RST = 8'h80;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic [1:0]            tok_type;
        logic [7:0]            base_hi;
        logic [1:0]            base_lo;
        logic [1:0]            last_ep;
        logic [3:0]            rx_cnt;
        logic [7:0]            flags;
        logic [7:0]            mask;
        logic [3:0]            ctl;
        logic [6:0]            device_address;
        logic [2:0][7:0]       epa;
        logic [2:0][7:0]       epb;
        logic [IDLE_CNT_W-1:0] idle_cnt;
        logic                  suspend_request_flag_seen;
        logic                  forced_interface_reset_q;
        logic                  wake;
        logic                  se0_s1;
        logic                  se0_s2;
        logic                  rxd_s1;
        logic                  rxd_s2;
    } lsu_st_t;

endpackage

// ==== lsu_ep_ctrl.sv ====
// Endpoint control, bus event flags and AXI4-Lite register file of the USB interface
`timescale 1ns/1ps
`default_nettype none

module lsu_ep_ctrl
    import lsu_pkg::*;
#(
    parameter int SUSPEND_REQUEST_FLAG_IDLE_CYCLES = SUSPEND_REQUEST_FLAG_IDLE_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        usb_bus_reset,
    input  wire logic        sof_token,
    input  wire logic        resume_done,
    input  wire logic        bus_activity,
    input  wire logic        line_se0,
    input  wire logic        line_rxd,
    input  wire logic        xfer_ok,
    input  wire logic [1:0]  xfer_ep,
    input  wire logic [1:0]  xfer_tok,
    input  wire logic [3:0]  xfer_cnt,
    input  wire logic        xfer_err,
    input  wire logic        buf_overrun,
    input  wire logic        tok_valid,
    input  wire logic [6:0]  tok_addr,
    input  wire logic [3:0]  tok_ep,
    input  wire logic        tok_in,
    input  wire logic        cpu_int_mask,
    output logic [1:0]       hs_code,
    output logic [15:0]      buf_addr,
    output logic [3:0]       tx_count,
    output logic             data_toggle,
    output logic [6:0]       dev_addr,
    output logic             irq,
    output logic             cpu_wake,
    output logic             suspend_mode,
    output logic             regulator_off,
    output logic             resume_drive
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Register read mux: {mapped, data}
    function automatic logic [8:0] reg_read(input lsu_st_t s, input logic [5:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        unique case (idx)
            IDX_TOKEN:   r[7:0] = {s.tok_type, 3'h0, s.se0_s2, s.rxd_s2, 1'b0};
            IDX_BASE_HI: r[7:0] = s.base_hi;
            IDX_BASE_LO: r[7:0] = {s.base_lo, s.last_ep, s.rx_cnt};
            IDX_FLAGS:   r[7:0] = s.flags;
            IDX_MASK:    r[7:0] = s.mask;
            IDX_CTL:     r[7:0] = {4'h0, s.ctl};
            IDX_DEVICE_ADDRESS:   r[7:0] = {1'b0, s.device_address};
            IDX_EP0_TX:  r[7:0] = s.epa[0];
            IDX_EP0_RX:  r[7:0] = s.epb[0];
            IDX_EP1_TX:  r[7:0] = s.epa[1];
            IDX_EP1_RX:  r[7:0] = s.epb[1];
            IDX_EP2_TX:  r[7:0] = s.epa[2];
            IDX_EP2_RX:  r[7:0] = s.epb[2];
            default:     r = 9'h000;
        endcase
        return r;
    endfunction

    // Endpoint number lookup: {hit, index}
    function automatic logic [2:0] ep_lookup(input lsu_st_t s, input logic [3:0] num);
        logic [2:0] r;
        r = 3'h0;
        if (num == 4'h0) begin
            r = 3'h4;
        end else if (num == s.epb[1][3:0]) begin
            r = 3'h5;
        end else if (num == s.epb[2][3:0]) begin
            r = 3'h6;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    lsu_st_t st_reg;
    lsu_st_t st_next;

    logic       wr_go;
    logic       rd_go;
    logic       usb_rst;
    logic       forced_interface_reset_fall;
    logic [5:0] widx;
    logic [8:0] wmap;
    logic [8:0] rmap;
    logic [7:0] wd;
    logic [7:0] ev;
    logic [2:0] hit;
    logic [1:0] ep_stat;
    logic [2:0] slot;

    // Bus handshakes: write takes address and data together
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
    assign rd_go         = s_axi_arvalid && !st_reg.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = !st_reg.rvalid;
    assign widx          = s_axi_awaddr[7:2];
    assign wmap          = reg_read(st_reg, widx);
    assign rmap          = reg_read(st_reg, s_axi_araddr[7:2]);
    assign wd            = s_axi_wdata[7:0];
    assign usb_rst       = usb_bus_reset || st_reg.ctl[CTL_FORCED_INTERFACE_RESET];
    assign forced_interface_reset_fall     = st_reg.forced_interface_reset_q && !st_reg.ctl[CTL_FORCED_INTERFACE_RESET];

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        st_next        = st_reg;
        st_next.wake   = 1'b0;
        st_next.se0_s1 = line_se0;
        st_next.se0_s2 = st_reg.se0_s1;
        st_next.rxd_s1 = line_rxd;
        st_next.rxd_s2 = st_reg.rxd_s1;
        st_next.forced_interface_reset_q = st_reg.ctl[CTL_FORCED_INTERFACE_RESET];
        ev             = 8'h00;

        // Register writes; low byte lane only
        if (wr_go) begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = wmap[8] ? RESP_OKAY : RESP_SLVERR;
            if (wmap[8] && s_axi_wstrb[0]) begin
                unique case (widx)
                    IDX_BASE_HI: st_next.base_hi = wd;
                    IDX_BASE_LO: st_next.base_lo = wd[7:6];
                    IDX_FLAGS:   st_next.flags   = st_reg.flags & wd; // Zero clears
                    IDX_MASK:    st_next.mask    = wd;
                    IDX_CTL:     st_next.ctl     = wd[3:0];
                    IDX_DEVICE_ADDRESS:   st_next.device_address   = wd[6:0];
                    IDX_EP0_TX:  st_next.epa[0]  = wd;
                    IDX_EP0_RX:  st_next.epb[0]  = {1'b1, wd[6:4], 4'h0};
                    IDX_EP1_TX:  st_next.epa[1]  = wd;
                    IDX_EP1_RX:  st_next.epb[1]  = wd;
                    IDX_EP2_TX:  st_next.epa[2]  = wd;
                    IDX_EP2_RX:  st_next.epb[2]  = wd;
                    default:     st_next.bresp   = RESP_OKAY;
                endcase
            end
        end else if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // Register reads
        if (rd_go) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rmap[7:0];
            st_next.rresp  = rmap[8] ? RESP_OKAY : RESP_SLVERR;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // Frame markers
        if (sof_token || resume_done) begin
            ev[FLG_SOF] = 1'b1;
        end

        // Idle watch and wake-up
        if (bus_activity) begin
            st_next.idle_cnt  = '0;
            st_next.suspend_request_flag_seen = 1'b0;
            if (st_reg.ctl[CTL_FORCED_LOW_POWER]) begin
                st_next.ctl[CTL_FORCED_LOW_POWER] = 1'b0;
                ev[FLG_END_OF_SUSPEND_FLAG]          = 1'b1;
                st_next.wake           = 1'b1;
            end
        end else if (!st_reg.suspend_request_flag_seen) begin
            if (st_reg.idle_cnt == IDLE_CNT_W'(SUSPEND_REQUEST_FLAG_IDLE_CYCLES)) begin
                ev[FLG_SUSPEND_REQUEST_FLAG]      = 1'b1;
                st_next.suspend_request_flag_seen = 1'b1;
            end else begin
                st_next.idle_cnt = st_reg.idle_cnt + IDLE_CNT_W'(1);
            end
        end

        // Error and overrun reports
        ev[FLG_ERR]  = xfer_err;
        ev[FLG_BUFFER_OVERRUN_FLAG] = buf_overrun;

        // Completed transfer
        if (xfer_ok && !usb_rst) begin
            ev[FLG_CTR] = 1'b1;
            if (st_reg.flags[FLG_CTR]) begin
                ev[FLG_SERVICE_OVERRUN_FLAG] = 1'b1;
            end else begin
                st_next.tok_type = xfer_tok;
                st_next.last_ep  = xfer_ep;
                st_next.rx_cnt   = xfer_cnt;
            end
            if (xfer_tok == TOK_IN || xfer_tok == TOK_SETUP) begin
                st_next.epa[xfer_ep][EP_STH:EP_STL] = ST_NAK;
            end
            if (xfer_tok == TOK_OUT || xfer_tok == TOK_SETUP) begin
                st_next.epb[xfer_ep][EP_STH:EP_STL] = ST_NAK;
            end
            if (xfer_tok == TOK_SETUP) begin
                st_next.epa[xfer_ep][EP_DTOG] = 1'b1;
                st_next.epb[xfer_ep][EP_DTOG] = 1'b0;
            end
        end

        // USB reset, from the bus or forced by software
        if (usb_rst) begin
            st_next.device_address = 7'h00;
            for (int i = 0; i < 3; i++) begin
                st_next.epa[i][7:4] = 4'h0;
                st_next.epb[i][7:4] = 4'h0;
            end
            st_next.epb[0] = EP0RX_RST;
        end
        if (usb_bus_reset || forced_interface_reset_fall) begin
            ev[FLG_RST] = 1'b1;
        end

        // Hardware sets win over a software clear
        st_next.flags = st_next.flags | ev;
    end

    // Single state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg           <= '0;
            st_reg.ctl       <= CTL_RST;
            st_reg.epb[0]    <= EP0RX_RST;
            st_reg.rresp     <= RESP_OKAY;
            st_reg.bresp     <= RESP_OKAY;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Token answer and buffer addressing

    always_comb begin
        hit     = ep_lookup(st_reg, tok_ep);
        ep_stat = tok_in ? st_reg.epa[hit[1:0]][EP_STH:EP_STL]
                         : st_reg.epb[hit[1:0]][EP_STH:EP_STL];
        hs_code = ST_DIS;
        if (tok_valid && hit[2] && tok_addr == st_reg.device_address && !usb_rst) begin
            hs_code = ep_stat;
            if (ep_stat == ST_VALID && st_reg.flags[FLG_CTR]) begin
                hs_code = ST_NAK;
            end
        end
        slot        = {hit[1:0], 1'b0} + {2'b00, !tok_in};
        buf_addr    = {st_reg.base_hi, st_reg.base_lo, 6'h00}
                      | {10'h000, slot, 3'b000};
        tx_count    = st_reg.epa[hit[1:0]][3:0];
        data_toggle = tok_in ? st_reg.epa[hit[1:0]][EP_DTOG] : st_reg.epb[hit[1:0]][EP_DTOG];
    end

    // Outputs from state; irq is also gated by the cpu_int_mask input
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rdata   = {24'h000000, st_reg.rdata};
    assign dev_addr      = st_reg.device_address;
    assign irq           = |(st_reg.flags & st_reg.mask) && !cpu_int_mask;
    assign cpu_wake      = st_reg.wake;
    assign suspend_mode  = st_reg.ctl[CTL_FORCED_LOW_POWER];
    assign regulator_off = st_reg.ctl[CTL_REGULATOR_OFF_BIT];
    assign resume_drive  = st_reg.ctl[CTL_RESUME];

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_setup_done;
        xfer_ok && !usb_rst && xfer_tok == TOK_SETUP;
    endsequence

    sequence s_both_nak(logic [1:0] e);
        st_reg.epa[e][EP_STH:EP_STL] == ST_NAK && st_reg.epb[e][EP_STH:EP_STL] == ST_NAK;
    endsequence

    property p_ep0_fixed;
        st_reg.epb[0][7] && st_reg.epb[0][3:0] == 4'h0;
    endproperty
    a_ep0_fixed: assert property (p_ep0_fixed) else $error("ep0 rx fixed bits wrong");

    property p_bus_reset;
        usb_bus_reset |=> st_reg.device_address == 7'h00 && st_reg.epb[0] == EP0RX_RST
                          && st_reg.epa[1][EP_STH:EP_STL] == ST_DIS && st_reg.flags[FLG_RST];
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset effects missing");

    property p_ep0_reset;
        usb_rst |=> st_reg.epb[0] == 8'h80;
    endproperty
    a_ep0_reset: assert property (p_ep0_reset) else $error("ep0 rx not reset");

    property p_sof;
        (sof_token || resume_done) |=> st_reg.flags[FLG_SOF];
    endproperty
    a_sof: assert property (p_sof) else $error("frame flag not set");

    property p_suspend;
        !bus_activity && !st_reg.suspend_request_flag_seen
        && st_reg.idle_cnt == IDLE_CNT_W'(SUSPEND_REQUEST_FLAG_IDLE_CYCLES) |=> st_reg.flags[FLG_SUSPEND_REQUEST_FLAG];
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend flag missing");

    property p_wake;
        bus_activity && st_reg.ctl[CTL_FORCED_LOW_POWER] |=> cpu_wake && st_reg.flags[FLG_END_OF_SUSPEND_FLAG]
                                                  && !suspend_mode ##1 !cpu_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake sequence wrong");

    property p_in_nak;
        xfer_ok && !usb_rst && xfer_tok == TOK_IN
        |=> st_reg.epa[$past(xfer_ep)][EP_STH:EP_STL] == ST_NAK && st_reg.flags[FLG_CTR];
    endproperty
    a_in_nak: assert property (p_in_nak) else $error("IN not NAKed");

    property p_setup_nak;
        s_setup_done |=> s_both_nak($past(xfer_ep));
    endproperty
    a_setup_nak: assert property (p_setup_nak) else $error("SETUP not NAKed both");

    property p_ctr_nak;
        st_reg.flags[FLG_CTR] |-> hs_code != ST_VALID;
    endproperty
    a_ctr_nak: assert property (p_ctr_nak) else $error("valid answer during CTR");

    property p_hold;
        st_reg.flags[FLG_CTR] ##1 st_reg.flags[FLG_CTR]
        |-> $stable(st_reg.tok_type) && $stable(st_reg.last_ep);
    endproperty
    a_hold: assert property (p_hold) else $error("capture changed under CTR");

    property p_irq;
        (st_reg.flags & st_reg.mask) != 8'h00 && !cpu_int_mask |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_fill;
        buf_addr[2:0] == 3'b000 && buf_addr[15:6] == {st_reg.base_hi, st_reg.base_lo};
    endproperty
    a_fill: assert property (p_fill) else $error("buffer start misplaced");

endmodule

`default_nettype wire

// ==== lsu_host_model.sv ====
// Behavioural serial engine and host traffic feeding the endpoint control block
`timescale 1ns/1ps
`default_nettype none

module lsu_host_model (
    input  wire logic       aclk,
    output logic            usb_bus_reset,
    output logic            sof_token,
    output logic            resume_done,
    output logic            bus_activity,
    output logic            xfer_ok,
    output logic [1:0]      xfer_ep,
    output logic [1:0]      xfer_tok,
    output logic [3:0]      xfer_cnt
);
    // Quiet bus until traffic is commanded
    initial begin
        {usb_bus_reset, sof_token, resume_done, bus_activity, xfer_ok} = 5'h00;
        {xfer_ep, xfer_tok, xfer_cnt} = 8'h00;
    end

    // One correct transfer; its token and count are scrambled once it is over, its endpoint is kept
    task automatic xfer(input logic [1:0] ep, input logic [1:0] tok, input logic [3:0] cnt);
        {xfer_ok, xfer_ep, xfer_tok, xfer_cnt} <= {1'b1, ep, tok, cnt};
        @(posedge aclk);
        {xfer_ok, xfer_tok, xfer_cnt} <= {1'b0, ~tok, ~cnt};
        @(posedge aclk);
    endtask

    // Frame start, or end of a resume sequence
    task automatic frame(input bit res);
        {resume_done, sof_token} <= {res, ~res};
        @(posedge aclk);
        {resume_done, sof_token} <= 2'h0;
        @(posedge aclk);
    endtask

    // Bus reset held for n cycles
    task automatic bus_rst(input int n);
        usb_bus_reset <= 1'b1;
        repeat (n) @(posedge aclk);
        usb_bus_reset <= 1'b0;
        @(posedge aclk);
    endtask

    // Traffic resumes on the bus and stays
    task automatic act();
        bus_activity <= 1'b1;
    endtask
endmodule

`default_nettype wire

// ==== testbench.sv ====
// Register-level testbench of the endpoint control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lsu_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_arready, tok_valid, tok_in, cpu_int_mask, irq, cpu_wake, data_toggle;
    logic        usb_bus_reset, sof_token, resume_done, bus_activity, xfer_ok;
    logic        xfer_err, buf_overrun, suspend_mode, regulator_off, resume_drive;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rd;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, hs_code, xfer_ep, xfer_tok;
    logic [3:0]  xfer_cnt, tok_ep, tx_count, s_axi_wstrb, hs;
    logic [6:0]  tok_addr, dev_addr;
    logic [15:0] buf_addr;
    int          failures, compares, n;

    // Clock and bus handshake view
    initial aclk = 1'b0;
    always #4 aclk = ~aclk;
    assign hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};

    lsu_ep_ctrl #(.SUSPEND_REQUEST_FLAG_IDLE_CYCLES(20)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .usb_bus_reset, .sof_token,
        .resume_done, .bus_activity, .line_se0(1'b0), .line_rxd(1'b1), .xfer_ok, .xfer_ep,
        .xfer_tok, .xfer_cnt, .xfer_err, .buf_overrun, .tok_valid, .tok_addr,
        .tok_ep, .tok_in, .cpu_int_mask, .hs_code, .buf_addr, .tx_count, .data_toggle,
        .dev_addr, .irq, .cpu_wake, .suspend_mode, .regulator_off, .resume_drive);

    lsu_host_model host_u (.aclk, .usb_bus_reset, .sof_token, .resume_done, .bus_activity,
        .xfer_ok, .xfer_ep, .xfer_tok, .xfer_cnt);

    // Comparison and verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bounded wait for one handshake bit
    task automatic hold(input int k);
        int c;
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (hs[k] !== 1'b1 && c < 64);
        if (hs[k] !== 1'b1) begin
            failures++;
            results();
        end
    endtask

    // Register write and read over the register bus
    task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {idx, 2'h0, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        hold(0);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        hold(1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask

    task automatic rdr(input logic [5:0] idx, output logic [7:0] d,
                       input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        hold(2);
        s_axi_arvalid <= 1'b0;
        hold(3);
        s_axi_rready <= 1'b0;
        chk("rresp", s_axi_rresp, er);
        d = s_axi_rdata[7:0];
    endtask

    task automatic rc(input string nm, input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] d;
        rdr(idx, d);
        chk(nm, d, e);
    endtask

    // Token lookup answered in the same cycle
    task automatic tq(input logic [3:0] ep, input logic in_dir, input logic [1:0] e);
        @(posedge aclk);
        {tok_ep, tok_in, tok_valid} <= {ep, in_dir, 1'b1};
        @(posedge aclk);
        chk("hs_code", hs_code, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tok_ep, tok_in, tok_valid, cpu_int_mask} = 0;
        {s_axi_wstrb, tok_addr, failures, compares} = {4'h1, 7'h05, 64'h0};
        {xfer_err, buf_overrun} = 2'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc("flags", IDX_FLAGS, 8'h00);
        rc("ctl", IDX_CTL, 8'h06);
        rc("ep0rx", IDX_EP0_RX, 8'h80);
        repeat (20) @(posedge aclk);
        rc("flags", IDX_FLAGS, 8'h80);
        wr(IDX_CTL, 8'h06);
        chk("suspend_mode", suspend_mode, 1'b1);
        host_u.act();
        n = 0;
        repeat (4) begin
            @(posedge aclk);
            if (cpu_wake === 1'b1) n++;
        end
        chk("wake", n, 1);
        rc("ctl", IDX_CTL, 8'h04);
        rc("flags", IDX_FLAGS, 8'h84);
        chk("suspend_mode", suspend_mode, 1'b0);
        chk("regulator_off", regulator_off, 1'b1);
        $display("test suspend done");
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_EP0_RX, 8'h3f);
        rc("ep0rx", IDX_EP0_RX, 8'hb0);
        wr(IDX_BASE_HI, 8'h12);
        wr(IDX_BASE_LO, 8'h40);
        wr(IDX_DEVICE_ADDRESS, 8'h05);
        chk("dev_addr", dev_addr, 7'h05);
        wr(IDX_EP1_RX, 8'h31);
        wr(IDX_EP1_TX, 8'h33);
        tq(4'h1, 1'b0, ST_VALID);
        chk("buf_addr", buf_addr, 16'h1258);
        tq(4'h1, 1'b1, ST_VALID);
        chk("buf_addr", buf_addr, 16'h1250);
        chk("tx_count", tx_count, 4'h3);
        tq(4'h2, 1'b0, 2'h0);
        tok_addr <= 7'h06;
        tq(4'h1, 1'b0, 2'h0);
        tok_addr <= 7'h05;
        $display("test setup done");
        host_u.xfer(2'h1, TOK_OUT, 4'h5);
        rc("ep1rx", IDX_EP1_RX, 8'h21);
        rc("token", IDX_TOKEN, 8'h02);
        rc("base_lo", IDX_BASE_LO, 8'h55);
        tq(4'h1, 1'b1, ST_NAK);
        host_u.xfer(2'h0, TOK_SETUP, 4'h8);
        rc("token", IDX_TOKEN, 8'h02);
        rc("ep0rx", IDX_EP0_RX, 8'ha0);
        rc("ep0tx", IDX_EP0_TX, 8'h60);
        rc("flags", IDX_FLAGS, 8'h28);
        wr(IDX_FLAGS, 8'h00);
        tq(4'h1, 1'b1, ST_VALID);
        host_u.xfer(2'h0, TOK_SETUP, 4'h8);
        rc("token", IDX_TOKEN, 8'hc2);
        rc("base_lo", IDX_BASE_LO, 8'h48);
        tq(4'h0, 1'b1, ST_NAK);
        chk("data_toggle", data_toggle, 1'b1);
        host_u.xfer(2'h1, TOK_IN, 4'h0);
        rc("ep1tx", IDX_EP1_TX, 8'h23);
        $display("test transfer done");
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_MASK, 8'h01);
        chk("irq", irq, 1'b0);
        host_u.frame(1'b0);
        rc("flags", IDX_FLAGS, 8'h01);
        chk("irq", irq, 1'b1);
        cpu_int_mask <= 1'b1;
        @(posedge aclk);
        chk("irq", irq, 1'b0);
        wr(IDX_FLAGS, 8'h00);
        host_u.frame(1'b1);
        rc("flags", IDX_FLAGS, 8'h01);
        {xfer_err, buf_overrun} <= 2'h3;
        @(posedge aclk);
        {xfer_err, buf_overrun} <= 2'h0;
        rc("flags", IDX_FLAGS, 8'h51);
        $display("test events done");
        host_u.bus_rst(3);
        rc("device_address", IDX_DEVICE_ADDRESS, 8'h00);
        chk("dev_addr", dev_addr, 7'h00);
        rc("ep0rx", IDX_EP0_RX, 8'h80);
        rc("ep1rx", IDX_EP1_RX, 8'h01);
        rc("flags", IDX_FLAGS, 8'h53);
        tok_addr <= 7'h00;
        tq(4'h0, 1'b0, 2'h0);
        wr(IDX_EP0_RX, 8'h30);
        tq(4'h0, 1'b0, ST_VALID);
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_CTL, 8'h01);
        wr(IDX_CTL, 8'h08);
        rc("flags", IDX_FLAGS, 8'h02);
        rc("ep0rx", IDX_EP0_RX, 8'h80);
        chk("resume_drive", resume_drive, 1'b1);
        chk("regulator_off", regulator_off, 1'b0);
        rdr(6'h3f, rd, RESP_SLVERR);
        chk("unmapped", rd, 8'h00);
        wr(6'h00, 8'hff, RESP_SLVERR);
        $display("test reset done");
        results();
    end
endmodule

`default_nettype wire
